// *** pin_mux_pkg.sv ***
package pin_mux_pkg;

	// pin function codes held in nonvolatile configuration memory
	typedef enum logic [4:0] {
		FN_TRISTATE   = 5'h00,
		FN_DRIVE1     = 5'h01,
		FN_DRIVE0     = 5'h02,
		FN_RS485_EN   = 5'h03,
		FN_PWR_SWITCH = 5'h04,
		FN_TX_ACT     = 5'h05,
		FN_RX_ACT     = 5'h06,
		FN_ANYLED     = 5'h07,
		FN_SLEEP      = 5'h08,
		FN_CLK24      = 5'h09,
		FN_CLK12      = 5'h0a,
		FN_CLK6       = 5'h0b,
		FN_GPIO       = 5'h0c,
		FN_CHARGER    = 5'h0d,
		FN_CHARGER_N  = 5'h0e,
		FN_WR_STROBE  = 5'h0f,
		FN_RD_STROBE  = 5'h10,
		FN_VBUS_SENSE = 5'h11,
		FN_SOF_TOGGLE = 5'h12,
		FN_KEEP_AWAKE = 5'h13
	} pin_func_e;

	typedef struct packed {
		logic      pulldown_en;
		pin_func_e func;
	} pin_cfg_s;

	localparam pin_func_e FUNC_RESET     = FN_RS485_EN;
	localparam pin_cfg_s  CFG_RESET      = '{pulldown_en: 1'b0,
		func: FN_RS485_EN};

	// register port
	localparam int        ADDR_W         = 4;
	localparam int        DATA_W         = 8;
	localparam logic [3:0] REG_FUNC      = 4'h0;
	localparam logic [3:0] REG_GPIO      = 4'h1;
	localparam logic [3:0] REG_STATUS    = 4'h2;
	localparam int        GPIO_OUT_BIT   = 0;
	localparam int        GPIO_DRV_BIT   = 1;
	localparam int        GPIO_IN_BIT    = 4;
	localparam int        FUNC_PD_BIT    = 7;
	localparam logic [1:0] GPIO_RESET    = 2'h0;

	// clock rate and derived counts
	localparam longint    MCLK_HZ        = 100_000_000;
	localparam longint    MCLK_PERIOD_NS = 10;
	localparam longint    LED_PULSE_NS   = 10_000;
	localparam int        LED_PULSE_CYC  = int'((LED_PULSE_NS
		+ MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
	localparam int        LED_CNT_W      = 10;

	// phase-accumulator steps for the clock outputs
	localparam int        NCO_W          = 32;
	localparam longint    CLK24_HZ       = 24_000_000;
	localparam longint    CLK12_HZ       = 12_000_000;
	localparam longint    CLK6_HZ        = 6_000_000;
	localparam logic [31:0] NCO_STEP_24  =
		32'((CLK24_HZ << 32) / MCLK_HZ);
	localparam logic [31:0] NCO_STEP_12  =
		32'((CLK12_HZ << 32) / MCLK_HZ);
	localparam logic [31:0] NCO_STEP_6   =
		32'((CLK6_HZ << 32) / MCLK_HZ);

endpackage : pin_mux_pkg

// *** pin_sync3.sv ***
module pin_sync3
(
	input  wire logic i_mclk,  // device clock
	input  wire logic i_rst_n, // async reset, active low
	input  wire logic i_async, // level from outside the domain
	output logic      o_level  // filtered synchronous level
);

	logic meta_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_ff <= 1'b1;
			s2_ff   <= 1'b1;
			s3_ff   <= 1'b1;
		end
		else
		begin
			meta_ff <= i_async;
			s2_ff   <= meta_ff;
			s3_ff   <= s2_ff;
		end
	end

	// a change counts only once the second and third stages agree
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			level_ff <= 1'b1;
		else if (s2_ff == s3_ff)
			level_ff <= s3_ff;
	end

	assign o_level = level_ff;

endmodule : pin_sync3

// *** config_pin_function_mux.sv ***
// Notes on behaviour
// RULE_01: pin function comes from config memory; blank part gives tx-enable.
// RULE_02: options float the pin, drive constant one, or drive zero.
// RULE_03: tx-enable option drives pin high while serial data is sent.
// RULE_04: power option drives low after configuration, high in suspend.
// RULE_05: tx activity option pulses pin low when sending toward host.
// RULE_06: rx activity option pulses pin low when receiving from host.
// RULE_07: combined activity option pulses low on either direction.
// RULE_08: suspend option holds pin low during suspend, high otherwise.
// RULE_09: clock options output 24, 12 or 6 MHz; stopped in suspend.
// RULE_10: general purpose option lets software drive or read the pin.
// RULE_11: charger option drives high when dedicated charger detected.
// RULE_12: inverted charger option drives complement of charger flag.
// RULE_13: write strobe option outputs active-low bit-bang write strobe.
// RULE_14: read strobe option outputs active-low bit-bang read strobe.
// RULE_15: bus-power option makes pin an input sensing bus power.
// RULE_16: frame option toggles pin on each received start-of-frame.
// RULE_17: keep-awake option: low input blocks suspend when unplugged.
// RULE_18: input pins pulled up; pulled low in suspend when option set.
// RULE_19: code is loaded after reset and held until reset or reload.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
module config_pin_function_mux
(
	input  wire logic                    i_mclk,        // 100 MHz clock
	input  wire logic                    i_rst_n,       // async reset
	input  wire pin_mux_pkg::pin_cfg_s   i_nvm_cfg,     // stored code
	input  wire logic                    i_nvm_blank,   // unprogrammed
	input  wire logic                    i_nvm_load,    // reload pulse
	input  wire logic                    i_tx_busy,     // serial tx busy
	input  wire logic                    i_usb_cfgd,    // usb configured
	input  wire logic                    i_suspend,     // usb suspend
	input  wire logic                    i_usb_tx_act,  // data to host
	input  wire logic                    i_usb_rx_act,  // data from host
	input  wire logic                    i_charger,     // charger seen
	input  wire logic                    i_bb_wr_n,     // bit-bang wr
	input  wire logic                    i_bb_rd_n,     // bit-bang rd
	input  wire logic                    i_sof,         // sof pulse
	input  wire logic                    i_pin_in,      // pad input
	input  wire logic [3:0]              i_addr,        // reg address
	input  wire logic [7:0]              i_wdata,       // write data
	input  wire logic                    i_wr,          // write strobe
	input  wire logic                    i_rd,          // read strobe
	output logic [7:0]                   o_rdata,       // read data
	output logic                         o_pin_out,     // pad out level
	output logic                         o_pin_oe_n,    // pad drive, low
	output logic                         o_pull_up,     // weak pull-up
	output logic                         o_pull_down,   // weak pull-down
	output logic                         o_vbus_present,// bus power
	output logic                         o_keep_awake   // block suspend
);
	import pin_mux_pkg::*;

	function automatic logic is_input_func(input pin_func_e f,
		input logic gpio_drv);
		begin
			is_input_func = (f == FN_TRISTATE) || (f == FN_VBUS_SENSE)
				|| (f == FN_KEEP_AWAKE) || ((f == FN_GPIO) && !gpio_drv);
		end
	endfunction : is_input_func

	function automatic logic is_clk_func(input pin_func_e f);
		begin
			is_clk_func = (f == FN_CLK24) || (f == FN_CLK12)
				|| (f == FN_CLK6);
		end
	endfunction : is_clk_func

	pin_cfg_s               cfg_ff;
	logic                   load_pend_ff;
	logic                   cfg_load;
	logic [1:0]             gpio_ff;
	logic                   sof_tog_ff;
	logic [NCO_W-1:0]       nco_ff;
	logic [NCO_W-1:0]       nco_step;
	logic [LED_CNT_W-1:0]   led_cnt_ff [3];
	logic [2:0]             led_act;
	logic                   pin_sync;
	logic                   pin_out_ff;
	logic                   pin_oe_n_ff;
	logic                   pull_up_ff;
	logic                   pull_down_ff;
	logic                   vbus_ff;
	logic                   keep_awake_ff;
	logic [7:0]             rdata_ff;
	logic                   nxt_pin_out;
	logic                   nxt_pin_oe_n;
	logic [7:0]             nxt_rdata;

	pin_sync3 u_pin_sync
	(
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_async (i_pin_in),
		.o_level (pin_sync)
	);

	// configuration capture, first cycle after reset and on reload
	assign cfg_load = load_pend_ff || i_nvm_load;

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			load_pend_ff <= 1'b1;
		else
			load_pend_ff <= 1'b0;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cfg_ff <= CFG_RESET;
		else if (cfg_load)
		begin
			if (i_nvm_blank)
				cfg_ff <= CFG_RESET; // RULE_01
			else
				cfg_ff <= i_nvm_cfg; // RULE_19
		end
	end

	// software-owned pin state for the general purpose option
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			gpio_ff <= GPIO_RESET;
		else if (i_wr && (i_addr == REG_GPIO))
			gpio_ff <= {i_wdata[GPIO_DRV_BIT], i_wdata[GPIO_OUT_BIT]}; // RULE_10
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			sof_tog_ff <= 1'b0;
		else if (i_sof)
			sof_tog_ff <= !sof_tog_ff; // RULE_16
	end

	// phase accumulator; its top bit is the clock output
	always_comb
	begin
		case (cfg_ff.func)
			FN_CLK24: nco_step = NCO_STEP_24;
			FN_CLK12: nco_step = NCO_STEP_12;
			FN_CLK6:  nco_step = NCO_STEP_6;
			default:  nco_step = '0;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			nco_ff <= '0;
		else if (i_suspend || !is_clk_func(cfg_ff.func))
			nco_ff <= '0; // RULE_09
		else
			nco_ff <= nco_ff + nco_step; // RULE_09
	end

	// activity pulse stretchers: tx, rx, either
	assign led_act = {i_usb_tx_act || i_usb_rx_act, i_usb_rx_act,
		i_usb_tx_act};

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < 3; i++)
				led_cnt_ff[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (led_act[i])
					led_cnt_ff[i] <= LED_CNT_W'(LED_PULSE_CYC);
				else if (led_cnt_ff[i] != '0)
					led_cnt_ff[i] <= led_cnt_ff[i] - 1'b1;
			end
		end
	end

	// pad output selection
	always_comb
	begin
		nxt_pin_out  = 1'b1;
		nxt_pin_oe_n = 1'b0;
		case (cfg_ff.func)
			FN_TRISTATE:
				nxt_pin_oe_n = 1'b1; // RULE_02
			FN_DRIVE1:
				nxt_pin_out = 1'b1; // RULE_02
			FN_DRIVE0:
				nxt_pin_out = 1'b0; // RULE_02
			FN_RS485_EN:
				nxt_pin_out = i_tx_busy; // RULE_03
			FN_PWR_SWITCH:
				nxt_pin_out = !(i_usb_cfgd && !i_suspend); // RULE_04
			FN_TX_ACT:
				nxt_pin_out = (led_cnt_ff[0] == '0); // RULE_05
			FN_RX_ACT:
				nxt_pin_out = (led_cnt_ff[1] == '0); // RULE_06
			FN_ANYLED:
				nxt_pin_out = (led_cnt_ff[2] == '0); // RULE_07
			FN_SLEEP:
				nxt_pin_out = !i_suspend; // RULE_08
			FN_CLK24, FN_CLK12, FN_CLK6:
				nxt_pin_out = nco_ff[NCO_W-1]; // RULE_09
			FN_GPIO:
			begin
				nxt_pin_out  = gpio_ff[0]; // RULE_10
				nxt_pin_oe_n = !gpio_ff[1]; // RULE_10
			end
			FN_CHARGER:
				nxt_pin_out = i_charger; // RULE_11
			FN_CHARGER_N:
				nxt_pin_out = !i_charger; // RULE_12
			FN_WR_STROBE:
				nxt_pin_out = i_bb_wr_n; // RULE_13
			FN_RD_STROBE:
				nxt_pin_out = i_bb_rd_n; // RULE_14
			FN_VBUS_SENSE, FN_KEEP_AWAKE:
				nxt_pin_oe_n = 1'b1; // RULE_15 RULE_17
			FN_SOF_TOGGLE:
				nxt_pin_out = sof_tog_ff; // RULE_16
			default:
				nxt_pin_oe_n = 1'b1;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pin_out_ff  <= 1'b1;
			pin_oe_n_ff <= 1'b1;
		end
		else
		begin
			pin_out_ff  <= nxt_pin_out;
			pin_oe_n_ff <= nxt_pin_oe_n;
		end
	end

	// weak pulls on an input pad
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pull_up_ff   <= 1'b1;
			pull_down_ff <= 1'b0;
		end
		else if (is_input_func(cfg_ff.func, gpio_ff[1]))
		begin
			pull_down_ff <= cfg_ff.pulldown_en && i_suspend; // RULE_18
			pull_up_ff   <= !(cfg_ff.pulldown_en && i_suspend); // RULE_18
		end
		else
		begin
			pull_up_ff   <= 1'b0;
			pull_down_ff <= 1'b0;
		end
	end

	// sensed inputs
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			vbus_ff       <= 1'b0;
			keep_awake_ff <= 1'b0;
		end
		else
		begin
			vbus_ff       <= (cfg_ff.func == FN_VBUS_SENSE) && pin_sync; // RULE_15
			keep_awake_ff <= (cfg_ff.func == FN_KEEP_AWAKE) && !pin_sync; // RULE_17
		end
	end

	// register reads, data valid the cycle after the strobe
	always_comb
	begin
		nxt_rdata = 8'h00;
		case (i_addr)
			REG_FUNC:
			begin
				nxt_rdata[4:0]         = cfg_ff.func; // RULE_19
				nxt_rdata[FUNC_PD_BIT] = cfg_ff.pulldown_en;
			end
			REG_GPIO:
			begin
				nxt_rdata[GPIO_OUT_BIT] = gpio_ff[0];
				nxt_rdata[GPIO_DRV_BIT] = gpio_ff[1];
				nxt_rdata[GPIO_IN_BIT]  = pin_sync; // RULE_10
			end
			REG_STATUS:
				nxt_rdata[3:0] = {i_charger, i_suspend, keep_awake_ff,
					vbus_ff};
			default:
				nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rdata_ff <= 8'h00;
		else if (i_rd)
			rdata_ff <= nxt_rdata;
		else
			rdata_ff <= 8'h00;
	end

	assign o_rdata        = rdata_ff;
	assign o_pin_out      = pin_out_ff;
	assign o_pin_oe_n     = pin_oe_n_ff;
	assign o_pull_up      = pull_up_ff;
	assign o_pull_down    = pull_down_ff;
	assign o_vbus_present = vbus_ff;
	assign o_keep_awake   = keep_awake_ff;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	blank_default_a: assert property ( // RULE_01
		cfg_load && i_nvm_blank |=> cfg_ff.func == FN_RS485_EN)
		else $error("blank config did not select tx enable");

	const_drive_a: assert property ( // RULE_02
		cfg_ff.func == FN_DRIVE0 && !cfg_load
		|=> !o_pin_out && !o_pin_oe_n)
		else $error("drive zero option not driving low");

	tristate_pad_a: assert property ( // RULE_02
		cfg_ff.func == FN_TRISTATE && !cfg_load |=> o_pin_oe_n)
		else $error("tristate option is driving the pad");

	rs485_follow_a: assert property ( // RULE_03
		cfg_ff.func == FN_RS485_EN && !cfg_load
		|=> o_pin_out == $past(i_tx_busy))
		else $error("tx enable does not follow serial activity");

	pwr_switch_a: assert property ( // RULE_04
		cfg_ff.func == FN_PWR_SWITCH && !cfg_load
		|=> o_pin_out == $past(!i_usb_cfgd || i_suspend))
		else $error("power enable level wrong");

	tx_act_pulse_a: assert property ( // RULE_05
		cfg_ff.func == FN_TX_ACT && !cfg_load && i_usb_tx_act
		|=> (cfg_ff.func == FN_TX_ACT) [*2] |-> ##1 !o_pin_out)
		else $error("tx activity did not pulse pin low");

	sleep_level_a: assert property ( // RULE_08
		cfg_ff.func == FN_SLEEP && !cfg_load
		|=> o_pin_out == $past(!i_suspend))
		else $error("suspend indicator level wrong");

	clk_stop_a: assert property ( // RULE_09
		(is_clk_func(cfg_ff.func) && i_suspend && !cfg_load) [*2]
		|=> !o_pin_out)
		else $error("clock output runs during suspend");

	sof_toggle_a: assert property ( // RULE_16
		i_sof |=> sof_tog_ff != $past(sof_tog_ff))
		else $error("frame toggle missed a start of frame");

	pulldown_a: assert property ( // RULE_18
		cfg_ff.func == FN_TRISTATE && cfg_ff.pulldown_en && i_suspend
		&& !cfg_load |=> o_pull_down && !o_pull_up)
		else $error("suspend pull-down not applied");

	func_read_a: assert property ( // RULE_19
		i_rd && i_addr == REG_FUNC && !cfg_load
		|=> o_rdata[4:0] == cfg_ff.func)
		else $error("function register read wrong");

	rs485_en_c: cover property (
		cfg_ff.func == FN_RS485_EN && i_tx_busy ##1 o_pin_out);
	clk_run_c: cover property (
		is_clk_func(cfg_ff.func) && o_pin_out ##1 !o_pin_out);
	gpio_read_c: cover property (
		cfg_ff.func == FN_GPIO && i_rd && i_addr == REG_GPIO);
	keep_awake_c: cover property (o_keep_awake);

endmodule : config_pin_function_mux

// *** pin_pad_model.sv ***
module pin_pad_model
(
	input  wire logic i_mclk,      // device clock
	input  wire logic i_pin_out,   // level driven by the block
	input  wire logic i_pin_oe_n,  // block drives pad, low
	input  wire logic i_pull_up,   // weak pull-up on
	input  wire logic i_pull_down, // weak pull-down on
	input  wire logic i_ext_en,    // board drives the pad
	input  wire logic i_ext_val,   // level driven by the board
	output logic      o_pad        // resolved pad level
);
	timeunit 1ns;
	timeprecision 1ns;

	logic float_ff = 1'b0;

	// an undriven, unpulled pad must not look like a steady level
	always @(posedge i_mclk)
		float_ff <= ~float_ff;

	always_comb
	begin
		if (!i_pin_oe_n)
			o_pad = i_pin_out;
		else if (i_ext_en)
			o_pad = i_ext_val;
		else if (i_pull_down)
			o_pad = 1'b0;
		else if (i_pull_up)
			o_pad = 1'b1;
		else
			o_pad = float_ff;
	end
endmodule : pin_pad_model

// *** config_pin_function_mux_test.sv ***
module config_pin_function_mux_test;
	timeunit 1ns;
	timeprecision 1ns;
	import pin_mux_pkg::*;

	logic       mclk, rst_n, blank, nvm_load, tx_busy, usb_cfgd, suspend;
	logic       tx_act, rx_act, charger, bb_wr_n, bb_rd_n, sof, pad;
	logic       wr, rd, pin_out, oe_n, pull_up, pull_down, vbus, awake;
	logic       ext_en, ext_val;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	pin_cfg_s   nvm_cfg;
	int         mismatches = 0;
	int         checks_done = 0;

	config_pin_function_mux config_pin_function_mux_i (.i_mclk(mclk),
		.i_rst_n(rst_n), .i_nvm_cfg(nvm_cfg), .i_nvm_blank(blank),
		.i_nvm_load(nvm_load), .i_tx_busy(tx_busy), .i_usb_cfgd(usb_cfgd),
		.i_suspend(suspend), .i_usb_tx_act(tx_act), .i_usb_rx_act(rx_act),
		.i_charger(charger), .i_bb_wr_n(bb_wr_n), .i_bb_rd_n(bb_rd_n),
		.i_sof(sof), .i_pin_in(pad), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_pin_out(pin_out),
		.o_pin_oe_n(oe_n), .o_pull_up(pull_up), .o_pull_down(pull_down),
		.o_vbus_present(vbus), .o_keep_awake(awake));

	pin_pad_model pin_pad_model_i (.i_mclk(mclk), .i_pin_out(pin_out),
		.i_pin_oe_n(oe_n), .i_pull_up(pull_up), .i_pull_down(pull_down),
		.i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : tick

	task automatic chk_pin(input logic e_out, input logic e_oe_n);
		chk("pin_out", {7'h0, e_out}, {7'h0, pin_out});
		chk("pin_oe_n", {7'h0, e_oe_n}, {7'h0, oe_n});
	endtask : chk_pin

	task automatic load(input pin_func_e f, input logic pd);
		@(posedge mclk);
		nvm_cfg <= '{pulldown_en: pd, func: f};
		nvm_load <= 1'b1;
		@(posedge mclk);
		nvm_load <= 1'b0;
		tick(3);
	endtask : load

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		chk("rdata", e, rdata);
	endtask : reg_rd

	// stimulus bits: charger, wr strobe, rd strobe, suspend, configured
	task automatic lvl(input pin_func_e f, input logic [4:0] s, input logic e);
		@(posedge mclk);
		{charger, bb_wr_n, bb_rd_n, suspend, usb_cfgd} <= s;
		load(f, 1'b0);
		chk_pin(e, 1'b0);
	endtask : lvl

	task automatic blank_default;
		tick(3);
		chk_pin(1'b0, 1'b0);
		@(posedge mclk);
		tx_busy <= 1'b1;
		tick(2);
		chk_pin(1'b1, 1'b0);
		reg_rd(REG_FUNC, 8'h03);
		@(posedge mclk);
		tx_busy <= 1'b0;
		blank <= 1'b0;
	endtask : blank_default

	task automatic led(input pin_func_e f, input logic tx, input logic rx,
		input logic p);
		load(f, 1'b0);
		@(posedge mclk);
		tx_act <= tx;
		rx_act <= rx;
		@(posedge mclk);
		tx_act <= 1'b0;
		rx_act <= 1'b0;
		tick(3);
		chk_pin(!p, 1'b0);
		tick(990);
		chk_pin(!p, 1'b0);
		tick(20);
		chk_pin(1'b1, 1'b0);
	endtask : led

	task automatic clk_out(input pin_func_e f, input int e);
		int   n;
		logic prev;
		n = 0;
		load(f, 1'b0);
		prev = pin_out;
		repeat (1000)
		begin
			@(negedge mclk);
			if (pin_out === 1'b1 && prev === 1'b0)
				n++;
			prev = pin_out;
		end
		chk("clk_rises_ok", 8'h1, {7'h0, (n >= e - 1 && n <= e + 1)});
		@(posedge mclk);
		suspend <= 1'b1;
		tick(4);
		n = 0;
		repeat (100)
		begin
			@(negedge mclk);
			if (pin_out !== 1'b0)
				n++;
		end
		chk("clk_stopped", 8'h0, n[7:0]);
		@(posedge mclk);
		suspend <= 1'b0;
	endtask : clk_out

	task automatic gpio_bits;
		load(FN_GPIO, 1'b0);
		reg_wr(REG_GPIO, 8'h03);
		tick(8);
		chk_pin(1'b1, 1'b0);
		reg_rd(REG_GPIO, 8'h13);
		reg_wr(REG_GPIO, 8'h01);
		@(posedge mclk);
		ext_en <= 1'b1;
		ext_val <= 1'b0;
		tick(8);
		chk("oe_n", 8'h1, {7'h0, oe_n});
		reg_rd(REG_GPIO, 8'h01);
		reg_wr(REG_FUNC, 8'h00);
		reg_rd(REG_FUNC, 8'h0c);
		reg_rd(4'hf, 8'h00);
	endtask : gpio_bits

	task automatic sense_inputs;
		load(FN_VBUS_SENSE, 1'b0);
		@(posedge mclk);
		ext_val <= 1'b1;
		tick(10);
		chk("vbus", 8'h1, {7'h0, vbus});
		chk("oe_n", 8'h1, {7'h0, oe_n});
		reg_rd(REG_STATUS, 8'h01);
		@(posedge mclk);
		ext_val <= 1'b0;
		tick(10);
		chk("vbus", 8'h0, {7'h0, vbus});
		load(FN_KEEP_AWAKE, 1'b0);
		chk("awake", 8'h1, {7'h0, awake});
		@(posedge mclk);
		ext_val <= 1'b1;
		tick(10);
		chk("awake", 8'h0, {7'h0, awake});
		@(posedge mclk);
		ext_en <= 1'b0;
	endtask : sense_inputs

	task automatic pulls;
		load(FN_TRISTATE, 1'b1);
		chk("pulls", 8'h6, {5'h0, oe_n, pull_up, pull_down});
		reg_rd(REG_FUNC, 8'h80);
		@(posedge mclk);
		suspend <= 1'b1;
		tick(3);
		chk("pulls", 8'h5, {5'h0, oe_n, pull_up, pull_down});
		load(FN_TRISTATE, 1'b0);
		chk("pulls", 8'h6, {5'h0, oe_n, pull_up, pull_down});
		@(posedge mclk);
		suspend <= 1'b0;
	endtask : pulls

	task automatic frame_toggle;
		logic v;
		load(FN_SOF_TOGGLE, 1'b0);
		v = pin_out;
		repeat (2)
		begin
			@(posedge mclk);
			sof <= 1'b1;
			@(posedge mclk);
			sof <= 1'b0;
			tick(3);
			v = ~v;
			chk_pin(v, 1'b0);
		end
	endtask : frame_toggle

	initial
	begin
		{rst_n, nvm_load, tx_busy, usb_cfgd, suspend, tx_act, rx_act} = '0;
		{charger, sof, wr, rd, ext_en, ext_val, addr, wdata} = '0;
		{bb_wr_n, bb_rd_n, blank} = 3'h7;
		nvm_cfg = '{pulldown_en: 1'b0, func: FN_DRIVE1};
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		blank_default;
		lvl(FN_DRIVE1, 5'h0c, 1'b1);
		lvl(FN_DRIVE0, 5'h0c, 1'b0);
		lvl(FN_PWR_SWITCH, 5'h0c, 1'b1);
		lvl(FN_PWR_SWITCH, 5'h0d, 1'b0);
		lvl(FN_PWR_SWITCH, 5'h0f, 1'b1);
		lvl(FN_SLEEP, 5'h0e, 1'b0);
		lvl(FN_SLEEP, 5'h0c, 1'b1);
		lvl(FN_CHARGER, 5'h1c, 1'b1);
		lvl(FN_CHARGER, 5'h0c, 1'b0);
		lvl(FN_CHARGER_N, 5'h1c, 1'b0);
		lvl(FN_WR_STROBE, 5'h04, 1'b0);
		lvl(FN_WR_STROBE, 5'h08, 1'b1);
		lvl(FN_RD_STROBE, 5'h08, 1'b0);
		lvl(FN_RD_STROBE, 5'h04, 1'b1);
		led(FN_TX_ACT, 1'b1, 1'b0, 1'b1);
		led(FN_TX_ACT, 1'b0, 1'b1, 1'b0);
		led(FN_RX_ACT, 1'b0, 1'b1, 1'b1);
		led(FN_ANYLED, 1'b1, 1'b0, 1'b1);
		led(FN_ANYLED, 1'b0, 1'b1, 1'b1);
		clk_out(FN_CLK24, 240);
		clk_out(FN_CLK12, 120);
		clk_out(FN_CLK6, 60);
		gpio_bits;
		sense_inputs;
		pulls;
		frame_toggle;
		load(FN_DRIVE1, 1'b0);
		@(posedge mclk);
		nvm_cfg <= '{pulldown_en: 1'b0, func: FN_DRIVE0};
		tick(4);
		chk_pin(1'b1, 1'b0);
		end_sim;
	end
endmodule : config_pin_function_mux_test
